//--- rtcs_top.sv
`timescale 1ns/100ps
`default_nettype none

module rtcs_top #(
  parameter int unsigned HOLDOFF_CYC = rtcs_pkg::HOLDOFF_CYCLES,
  parameter int unsigned LOCK_CYC = rtcs_pkg::LOCK_CYCLES
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic oscClk,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic testPinOut,
  output logic testPinOe,
  input wire logic powerFail,
  input wire logic onBackup
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_TXACK
  } rtcs_state_e;

  typedef struct packed {
    logic [1:0] sclSy;
    logic [1:0] sdaSy;
    logic [1:0] pfSy;
    logic [1:0] bkSy;
    logic [1:0] sqSy;
    logic [2:0] tickSy;
    logic sclD;
    logic sdaD;
    rtcs_state_e st;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic isAddr;
    logic rdMode;
    logic needWa;
    logic advFlag;
    logic [5:0] ptr;
    logic [rtcs_pkg::MEM_DEPTH-1:0][7:0] mem;
    logic [2:0] pend;
    logic [rtcs_pkg::WAIT_W-1:0] holdCnt;
    logic [rtcs_pkg::WAIT_W-1:0] lockCnt;
    logic locked;
    logic sdaOe;
    logic pinOe;
  } rtcs_core_s;

  typedef struct packed {
    logic [1:0] rstSy;
    logic [1:0] haltSy;
    logic [rtcs_pkg::OSC_DIV_W-1:0] div;
    logic tickTgl;
  } rtcs_osc_s;

  rtcs_core_s core_reg, core_next;
  rtcs_osc_s osc_reg, osc_next;

  localparam logic [rtcs_pkg::WAIT_W-1:0] HOLD_LOAD =
    rtcs_pkg::WAIT_W'(HOLDOFF_CYC);
  localparam logic [rtcs_pkg::WAIT_W-1:0] LOCK_LOAD =
    rtcs_pkg::WAIT_W'(LOCK_CYC);

  // BCD increment with wrap to a floor value; bit 8 is the carry out
  function automatic logic [8:0] bcdInc(input logic [7:0] v,
                                        input logic [7:0] top,
                                        input logic [7:0] floor);
    logic [8:0] res;
    res = 9'h000;
    if (v >= top) begin
      res = {1'b1, floor};
    end else if (v[3:0] >= 4'h9) begin
      res = {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      res = {1'b0, v[7:4], v[3:0] + 4'h1};
    end
    return res;
  endfunction

  // last day of the month; year divisible by 4 counts as leap
  function automatic logic [7:0] monthDays(input logic [7:0] mo,
                                           input logic [7:0] yr);
    logic [7:0] days;
    logic [1:0] yrMod;
    days = rtcs_pkg::DAYS_31;
    yrMod = yr[1:0] + {yr[4], 1'b0};
    if (mo == 8'h02) begin
      days = (yrMod == 2'h0) ? rtcs_pkg::DAYS_29 : rtcs_pkg::DAYS_28;
    end else if (mo == 8'h04 || mo == 8'h06 || mo == 8'h09 ||
                 mo == 8'h11) begin
      days = rtcs_pkg::DAYS_30;
    end
    return days;
  endfunction

  // timebase domain: divider, one-second toggle and 512 Hz tap
  always_comb begin
    osc_next = osc_reg;
    osc_next.rstSy = {osc_reg.rstSy[0], sys_rst};
    osc_next.haltSy = {osc_reg.haltSy[0],
                       core_reg.mem[rtcs_pkg::ADDR_SEC][rtcs_pkg::HALT_BIT]};
    if (osc_reg.rstSy[1]) begin
      osc_next.div = '0;
      osc_next.tickTgl = 1'b0;
    end else if (osc_reg.haltSy[1]) begin
      // halted divider restarts from zero, first second is a full one
      osc_next.div = '0;
    end else begin
      osc_next.div = osc_reg.div + 1'b1;
      if (&osc_reg.div) begin
        osc_next.tickTgl = ~osc_reg.tickTgl;
      end
    end
  end

  always_ff @(posedge oscClk) begin
    osc_reg <= osc_next;
  end

  logic sclS, sdaS, pfS, bkS, sclRise, sclFall, startEv, stopEv;
  logic tickEv, reading, applyTick, lvl;
  logic [7:0] secV, minV, hourV, wdayV, dateV, monV, yearV;
  logic [8:0] incR;

  assign sclS = core_reg.sclSy[1];
  assign sdaS = core_reg.sdaSy[1];
  assign pfS = core_reg.pfSy[1];
  assign bkS = core_reg.bkSy[1];
  assign sclRise = sclS & ~core_reg.sclD;
  assign sclFall = ~sclS & core_reg.sclD;
  assign startEv = sclS & core_reg.sclD & core_reg.sdaD & ~sdaS;
  assign stopEv = sclS & core_reg.sclD & ~core_reg.sdaD & sdaS;
  assign tickEv = core_reg.tickSy[2] ^ core_reg.tickSy[1];

  always_comb begin
    core_next = core_reg;
    core_next.sclSy = {core_reg.sclSy[0], sclIn};
    core_next.sdaSy = {core_reg.sdaSy[0], sdaIn};
    core_next.pfSy = {core_reg.pfSy[0], powerFail};
    core_next.bkSy = {core_reg.bkSy[0], onBackup};
    core_next.sqSy = {core_reg.sqSy[0], osc_reg.div[rtcs_pkg::SQ_TAP]};
    core_next.tickSy = {core_reg.tickSy[1:0], osc_reg.tickTgl};
    core_next.sclD = sclS;
    core_next.sdaD = sdaS;
    secV = core_reg.mem[rtcs_pkg::ADDR_SEC];
    minV = core_reg.mem[rtcs_pkg::ADDR_MIN];
    hourV = core_reg.mem[rtcs_pkg::ADDR_HOUR];
    wdayV = core_reg.mem[rtcs_pkg::ADDR_WDAY];
    dateV = core_reg.mem[rtcs_pkg::ADDR_DATE];
    monV = core_reg.mem[rtcs_pkg::ADDR_MONTH];
    yearV = core_reg.mem[rtcs_pkg::ADDR_YEAR];
    incR = 9'h000;

    // seconds owed to the calendar; counted up to PEND_MAX, further ticks dropped
    if (tickEv && core_reg.pend != rtcs_pkg::PEND_MAX) begin
      core_next.pend = core_reg.pend + 3'h1;
    end
    reading = (core_reg.st == ST_TX || core_reg.st == ST_TXACK) &&
              core_reg.ptr <= rtcs_pkg::ADDR_YEAR;
    applyTick = (core_reg.pend != 3'h0) &&
                (!reading || core_reg.holdCnt == '0);
    if (reading && core_reg.pend != 3'h0 && core_reg.holdCnt != '0) begin
      core_next.holdCnt = core_reg.holdCnt - 1'b1;
    end else if (!reading) begin
      core_next.holdCnt = HOLD_LOAD;
    end

    if (applyTick) begin
      core_next.pend = core_next.pend - 3'h1;
      incR = bcdInc({1'b0, secV[6:0]}, rtcs_pkg::SEC_MAX,
                    rtcs_pkg::ZERO_BCD);
      secV = {secV[rtcs_pkg::HALT_BIT], incR[6:0]};
      if (incR[8]) begin
        incR = bcdInc({1'b0, minV[6:0]}, rtcs_pkg::MIN_MAX,
                      rtcs_pkg::ZERO_BCD);
        minV = {minV[7], incR[6:0]};
        if (incR[8]) begin
          incR = bcdInc({2'b00, hourV[5:0]}, rtcs_pkg::HOUR_MAX,
                        rtcs_pkg::ZERO_BCD);
          hourV = {hourV[7:6], incR[5:0]};
          if (incR[8]) begin
            incR = bcdInc({5'h00, wdayV[2:0]}, rtcs_pkg::WDAY_MAX,
                          rtcs_pkg::ONE_BCD);
            wdayV = {wdayV[7:3], incR[2:0]};
            incR = bcdInc({2'b00, dateV[5:0]}, monthDays(monV, yearV),
                          rtcs_pkg::ONE_BCD);
            dateV = {dateV[7:6], incR[5:0]};
            if (incR[8]) begin
              incR = bcdInc({3'h0, monV[4:0]}, rtcs_pkg::MONTH_MAX,
                            rtcs_pkg::ONE_BCD);
              monV = {monV[7:5], incR[4:0]};
              if (incR[8]) begin
                incR = bcdInc(yearV, rtcs_pkg::YEAR_MAX,
                              rtcs_pkg::ZERO_BCD);
                yearV = incR[7:0];
                if (incR[8] && hourV[rtcs_pkg::CEB_BIT]) begin
                  hourV[rtcs_pkg::CB_BIT] = ~hourV[rtcs_pkg::CB_BIT];
                end
              end
            end
          end
        end
      end
      core_next.mem[rtcs_pkg::ADDR_SEC] = secV;
      core_next.mem[rtcs_pkg::ADDR_MIN] = minV;
      core_next.mem[rtcs_pkg::ADDR_HOUR] = hourV;
      core_next.mem[rtcs_pkg::ADDR_WDAY] = wdayV;
      core_next.mem[rtcs_pkg::ADDR_DATE] = dateV;
      core_next.mem[rtcs_pkg::ADDR_MONTH] = monV;
      core_next.mem[rtcs_pkg::ADDR_YEAR] = yearV;
    end

    // serial bus engine; writes below win over a same-cycle tick
    if (pfS) begin
      core_next.st = ST_IDLE;
      core_next.ptr = '0;
      core_next.sdaOe = 1'b0;
      core_next.locked = 1'b1;
      core_next.lockCnt = LOCK_LOAD;
    end else if (core_reg.locked) begin
      core_next.st = ST_IDLE;
      core_next.sdaOe = 1'b0;
      if (core_reg.lockCnt == '0) begin
        core_next.locked = 1'b0;
      end else begin
        core_next.lockCnt = core_reg.lockCnt - 1'b1;
      end
    end else if (stopEv) begin
      core_next.st = ST_IDLE;
      core_next.sdaOe = 1'b0;
    end else if (startEv) begin
      // a repeated start keeps the pointer as it is
      core_next.st = ST_RX;
      core_next.bitCnt = 4'h0;
      core_next.isAddr = 1'b1;
      core_next.sdaOe = 1'b0;
    end else begin
      case (core_reg.st)
        ST_RX: begin
          if (sclRise && core_reg.bitCnt != rtcs_pkg::BITS_PER_BYTE) begin
            core_next.shift = {core_reg.shift[6:0], sdaS};
            core_next.bitCnt = core_reg.bitCnt + 4'h1;
          end else if (sclFall &&
                       core_reg.bitCnt == rtcs_pkg::BITS_PER_BYTE) begin
            core_next.advFlag = 1'b0;
            core_next.st = ST_ACK;
            core_next.sdaOe = 1'b1;
            if (core_reg.isAddr) begin
              core_next.isAddr = 1'b0;
              if (core_reg.shift[7:1] == rtcs_pkg::SLAVE_BYTE[7:1]) begin
                core_next.rdMode = core_reg.shift[0];
                core_next.needWa = ~core_reg.shift[0];
              end else begin
                core_next.st = ST_IDLE;
                core_next.sdaOe = 1'b0;
              end
            end else if (core_reg.needWa) begin
              core_next.needWa = 1'b0;
              core_next.ptr = core_reg.shift[5:0];
            end else begin
              core_next.mem[core_reg.ptr] = core_reg.shift;
              core_next.advFlag = 1'b1;
            end
          end
        end
        ST_ACK: begin
          // held low from the fall before the ninth clock to the fall
          // after it, so it is steady through the high phase
          if (sclFall) begin
            core_next.sdaOe = 1'b0;
            if (core_reg.advFlag) begin
              core_next.ptr = core_reg.ptr + 6'h01;
            end
            if (core_reg.rdMode) begin
              core_next.st = ST_TX;
              core_next.shift = core_reg.mem[core_reg.ptr];
              core_next.sdaOe = ~core_reg.mem[core_reg.ptr][7];
              core_next.bitCnt = 4'h1;
            end else begin
              core_next.st = ST_RX;
              core_next.bitCnt = 4'h0;
            end
          end
        end
        ST_TX: begin
          if (sclFall) begin
            if (core_reg.bitCnt == rtcs_pkg::BITS_PER_BYTE) begin
              core_next.sdaOe = 1'b0;
              core_next.advFlag = 1'b0;
              core_next.st = ST_TXACK;
            end else begin
              core_next.shift = {core_reg.shift[6:0], 1'b0};
              core_next.sdaOe = ~core_reg.shift[6];
              core_next.bitCnt = core_reg.bitCnt + 4'h1;
            end
          end
        end
        ST_TXACK: begin
          if (sclRise) begin
            if (!sdaS) begin
              core_next.ptr = core_reg.ptr + 6'h01;
              core_next.advFlag = 1'b1;
            end else begin
              core_next.st = ST_IDLE;
            end
          end else if (sclFall && core_reg.advFlag) begin
            core_next.st = ST_TX;
            core_next.shift = core_reg.mem[core_reg.ptr];
            core_next.sdaOe = ~core_reg.mem[core_reg.ptr][7];
            core_next.bitCnt = 4'h1;
          end
        end
        default: begin
          core_next.sdaOe = 1'b0;
        end
      endcase
    end

    // open-drain test pin: pulls low only for a low level
    lvl = core_reg.mem[rtcs_pkg::ADDR_CTRL][rtcs_pkg::FT_BIT] ?
          core_reg.sqSy[1] :
          core_reg.mem[rtcs_pkg::ADDR_CTRL][rtcs_pkg::OUT_BIT];
    core_next.pinOe = ~lvl;
    if (bkS) begin
      core_next.sdaOe = 1'b0;
      core_next.pinOe = 1'b0;
      core_next.st = ST_IDLE;
    end

    if (sys_rst) begin
      core_next = '0;
      core_next.st = ST_IDLE;
      core_next.holdCnt = HOLD_LOAD;
      core_next.sclSy = 2'b11;
      core_next.sdaSy = 2'b11;
      core_next.sclD = 1'b1;
      core_next.sdaD = 1'b1;
      core_next.mem[rtcs_pkg::ADDR_WDAY] = rtcs_pkg::ONE_BCD;
      core_next.mem[rtcs_pkg::ADDR_DATE] = rtcs_pkg::ONE_BCD;
      core_next.mem[rtcs_pkg::ADDR_MONTH] = rtcs_pkg::ONE_BCD;
      // trim magnitude bits 4..0 and sign bit 5 stored as written
      core_next.mem[rtcs_pkg::ADDR_CTRL] = rtcs_pkg::CTRL_RESET;
    end
  end

  always_ff @(posedge core_clk) begin
    core_reg <= core_next;
  end

  assign sdaOut = 1'b0;
  assign testPinOut = 1'b0;
  assign sdaOe = core_reg.sdaOe;
  assign testPinOe = core_reg.pinOe;

endmodule

`default_nettype wire

//--- rtcs_pkg.sv
`default_nettype none
package rtcs_pkg;
  // bus framing
  localparam logic [7:0] SLAVE_BYTE = 8'hD0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // register map
  localparam int MEM_DEPTH = 64;
  localparam logic [5:0] ADDR_SEC = 6'h00;
  localparam logic [5:0] ADDR_MIN = 6'h01;
  localparam logic [5:0] ADDR_HOUR = 6'h02;
  localparam logic [5:0] ADDR_WDAY = 6'h03;
  localparam logic [5:0] ADDR_DATE = 6'h04;
  localparam logic [5:0] ADDR_MONTH = 6'h05;
  localparam logic [5:0] ADDR_YEAR = 6'h06;
  localparam logic [5:0] ADDR_CTRL = 6'h07;

  // field positions
  localparam int HALT_BIT = 7;
  localparam int CEB_BIT = 7;
  localparam int CB_BIT = 6;
  localparam int OUT_BIT = 7;
  localparam int FT_BIT = 6;
  localparam int SIGN_BIT = 5;
  localparam int CAL_MSB = 4;

  // values after reset
  localparam logic [7:0] CTRL_RESET = 8'h80;
  localparam logic [7:0] ONE_BCD = 8'h01;
  localparam logic [7:0] ZERO_BCD = 8'h00;

  // counting limits, BCD
  localparam logic [7:0] SEC_MAX = 8'h59;
  localparam logic [7:0] MIN_MAX = 8'h59;
  localparam logic [7:0] HOUR_MAX = 8'h23;
  localparam logic [7:0] WDAY_MAX = 8'h07;
  localparam logic [7:0] MONTH_MAX = 8'h12;
  localparam logic [7:0] YEAR_MAX = 8'h99;
  localparam logic [7:0] DAYS_31 = 8'h31;
  localparam logic [7:0] DAYS_30 = 8'h30;
  localparam logic [7:0] DAYS_29 = 8'h29;
  localparam logic [7:0] DAYS_28 = 8'h28;

  // timing
  localparam int CORE_CLK_KHZ = 250000;
  localparam int HOLDOFF_MS = 250;
  localparam int HOLDOFF_CYCLES = HOLDOFF_MS * CORE_CLK_KHZ;
  localparam int LOCK_TIME_US = 200;
  localparam int LOCK_CYCLES = (LOCK_TIME_US * CORE_CLK_KHZ) / 1000;
  localparam int WAIT_W = 26;
  localparam logic [2:0] PEND_MAX = 3'h7;

  // timebase: 15-bit divider of the 32768 Hz clock, tap 5 is 512 Hz
  localparam int OSC_DIV_W = 15;
  localparam int SQ_TAP = 5;
endpackage
`default_nettype wire

//--- rtcs_top_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module rtcs_monitor #(
  parameter int unsigned HOLDOFF_CYC = 200,
  parameter int unsigned LOCK_CYC = 50
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic oscClk,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic testPinOut,
  input wire logic testPinOe,
  input wire logic powerFail,
  input wire logic onBackup
);
  logic sclD, sdaD, firstByte, nacked, blocked;
  logic [3:0] bitCnt;
  logic [7:0] shift, addr;
  int unsigned lockCnt;
  wire logic isStart = sclD & sclIn & sdaD & ~sdaIn;
  wire logic ackRise = ~sclD & sclIn & (bitCnt == 4'h8);
  wire logic ourId = firstByte ? shift[7:1] == rtcs_pkg::SLAVE_BYTE[7:1]
    : addr == rtcs_pkg::SLAVE_BYTE;
  always_ff @(posedge core_clk) begin
    sclD <= sclIn;
    sdaD <= sdaIn;
    if (sys_rst)
      lockCnt <= 0;
    else if (powerFail)
      lockCnt <= LOCK_CYC;
    else if (lockCnt != 0)
      lockCnt <= lockCnt - 1;
    // a transfer opened while locked stays excluded until the next start
    if (powerFail || onBackup || lockCnt != 0)
      blocked <= 1'b1;
    else if (isStart || sys_rst)
      blocked <= 1'b0;
    if (sys_rst || isStart) begin
      bitCnt <= 4'h0;
      firstByte <= 1'b1;
      nacked <= 1'b0;
    end else if (~sclD & sclIn) begin
      shift <= {shift[6:0], sdaIn};
      bitCnt <= (bitCnt == 4'h8) ? 4'h0 : bitCnt + 4'h1;
      if (bitCnt == 4'h8) begin
        firstByte <= 1'b0;
        nacked <= sdaIn & ~firstByte & addr[0];
      end
      if (bitCnt == 4'h8 && firstByte)
        addr <= shift;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_ackOurs;
    ackRise && ourId && !blocked |-> sdaOe;
  endproperty
  a_ackOurs: assert property (p_ackOurs)
    else $error("byte not acked");
  property p_otherIgnored;
    ackRise && firstByte && !ourId |-> !sdaOe;
  endproperty
  a_otherIgnored: assert property (p_otherIgnored)
    else $error("foreign ack");
  property p_nackRelease;
    nacked |-> !sdaOe;
  endproperty
  a_nackRelease: assert property (p_nackRelease)
    else $error("held after nack");
  property p_stableHigh;
    sclIn && sclD && !blocked && !powerFail && !onBackup |-> $stable(sdaOe);
  endproperty
  a_stableHigh: assert property (p_stableHigh)
    else $error("data moved");
  property p_ackDelay;
    $rose(sdaOe) |-> !sclIn && ($past(sclIn, 3) || $past(sclIn, 4)
      || $past(sclIn, 5) || $past(sclIn, 6));
  endproperty
  a_ackDelay: assert property (p_ackDelay)
    else $error("drive off fall");
  property p_backupOff;
    onBackup [*6] |-> !sdaOe && !testPinOe;
  endproperty
  a_backupOff: assert property (p_backupOff)
    else $error("drive on backup");
  property p_failOff;
    powerFail [*6] |-> !sdaOe;
  endproperty
  a_failOff: assert property (p_failOff) else $error("drive in fail");
  property p_recoveryLock;
    lockCnt != 0 && !powerFail |-> !sdaOe;
  endproperty
  a_recoveryLock: assert property (p_recoveryLock)
    else $error("early");
  c_ownAck: cover property (ackRise && sdaOe);
  c_nack: cover property (nacked);
  c_lockEnd: cover property (lockCnt == 1);
endmodule
bind rtcs_top rtcs_monitor #(
  .HOLDOFF_CYC(HOLDOFF_CYC),
  .LOCK_CYC(LOCK_CYC)
) u_rtcs_monitor (
  .core_clk(core_clk), .sys_rst(sys_rst), .oscClk(oscClk),
  .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .testPinOut(testPinOut), .testPinOe(testPinOe),
  .powerFail(powerFail), .onBackup(onBackup)
);
`default_nettype wire

//--- rtcs_bus_master.sv
`timescale 1ns/100ps
`default_nettype none
module rtcs_bus_master #(
  parameter int HALF = 30
) (
  input wire logic core_clk,
  input wire logic sdaOe,
  output logic sclIn,
  output logic sdaIn
);
  logic sdaDrv;
  // pulled-up wire: either party may pull it low
  assign sdaIn = sdaDrv & ~sdaOe;
  initial begin
    sclIn = 1'b1;
    sdaDrv = 1'b1;
  end
  task automatic waitc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // also a repeated start: data rises while the clock is still low
  task automatic start();
    sdaDrv <= 1'b1;
    waitc(HALF);
    sclIn <= 1'b1;
    waitc(HALF);
    sdaDrv <= 1'b0;
    waitc(1000);
    sclIn <= 1'b0;
  endtask
  task automatic stop();
    sdaDrv <= 1'b0;
    waitc(HALF);
    sclIn <= 1'b1;
    waitc(HALF);
    sdaDrv <= 1'b1;
    waitc(1175);
  endtask
  task automatic bitX(input logic b, output logic r);
    sdaDrv <= b;
    waitc(HALF);
    sclIn <= 1'b1;
    waitc(HALF);
    r = sdaIn;
    sclIn <= 1'b0;
  endtask
  // ackOut high leaves the ninth bit released, a nack when reading
  task automatic byteX(input logic [7:0] w, input logic ackOut,
      output logic [7:0] r, output logic ackIn);
    for (int i = 7; i >= 0; i--)
      bitX(w[i], r[i]);
    bitX(ackOut, ackIn);
  endtask
endmodule
`default_nettype wire

//--- test_rtcs_top.sv
`timescale 1ns/100ps
`default_nettype none
module test_rtcs_top;
  localparam int LOCK = 3000;
  localparam int TOG = 64 * 48 / 4 / 2;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic oscClk = 1'b0;
  logic powerFail = 1'b0;
  logic onBackup = 1'b0;
  logic sclIn, sdaIn, sdaOut, sdaOe, testPinOut, testPinOe, ak;
  logic [7:0] rd;
  logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'h01,
                         8'h01, 8'h01, 8'h00, 8'h80};
  logic [7:0] bad [3] = '{8'hD2, 8'h50, 8'hD8};
  int n_fail = 0;
  int n_checks = 0;
  always #2 core_clk = ~core_clk;
  initial begin
    #1.3;
    forever #24 oscClk = ~oscClk;
  end
  rtcs_top #(.HOLDOFF_CYC(200), .LOCK_CYC(LOCK)) u_rtcs_top (
    .core_clk(core_clk), .sys_rst(sys_rst), .oscClk(oscClk),
    .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .testPinOut(testPinOut), .testPinOe(testPinOe),
    .powerFail(powerFail), .onBackup(onBackup));
  rtcs_bus_master u_rtcs_bus_master (.core_clk(core_clk), .sdaOe(sdaOe),
    .sclIn(sclIn), .sdaIn(sdaIn));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic sendB(input logic [7:0] w, input logic expAck);
    u_rtcs_bus_master.byteX(w, 1'b1, rd, ak);
    check({7'h0, ak}, {7'h0, ~expAck});
  endtask
  task automatic open(input logic [7:0] id, input logic expAck);
    u_rtcs_bus_master.start();
    sendB(id, expAck);
  endtask
  task automatic rdB(input logic [7:0] exp, input logic last);
    u_rtcs_bus_master.byteX(8'hFF, last, rd, ak);
    check(rd, exp);
    if (last) begin
      u_rtcs_bus_master.waitc(10);
      check({7'h0, sdaOe}, 8'h00);
    end
  endtask
  task automatic wr1(input logic [7:0] a, input logic [7:0] d);
    open(8'hD0, 1'b1);
    sendB(a, 1'b1);
    sendB(d, 1'b1);
    u_rtcs_bus_master.stop();
  endtask
  // counts test pin edges over about two square-wave periods
  task automatic countTog(input int expLo, input int expHi);
    int n;
    logic p;
    n = 0;
    p = testPinOe;
    repeat (4 * TOG) begin
      @(posedge core_clk);
      if (testPinOe !== p)
        n++;
      p = testPinOe;
    end
    check({7'h0, n >= expLo && n <= expHi}, 8'h01);
  endtask
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge core_clk);
    n_fail++;
    close_out();
  end
  initial begin
    // slow domain needs a few of its own edges in reset
    repeat (3) @(posedge oscClk);
    @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    open(8'hD1, 1'b1);
    for (int i = 0; i < 8; i++)
      rdB(rv[i], i == 7);
    u_rtcs_bus_master.stop();
    $display("test reset_read done");
    open(8'hD0, 1'b1);
    sendB(8'hFE, 1'b1);
    sendB(8'hA5, 1'b1);
    sendB(8'h5A, 1'b1);
    sendB(8'h80, 1'b1);
    u_rtcs_bus_master.stop();
    open(8'hD0, 1'b1);
    sendB(8'h3E, 1'b1);
    open(8'hD1, 1'b1);
    rdB(8'hA5, 1'b0);
    rdB(8'h5A, 1'b0);
    rdB(8'h80, 1'b0);
    rdB(8'h00, 1'b1);
    u_rtcs_bus_master.stop();
    $display("test write_wrap done");
    for (int i = 0; i < 3; i++) begin
      open(bad[i], 1'b0);
      u_rtcs_bus_master.stop();
    end
    $display("test foreign_id done");
    wr1(8'h07, 8'h00);
    check({7'h0, testPinOe}, 8'h01);
    wr1(8'h07, 8'h40);
    // seconds still carry the halt bit from the wrap test
    countTog(0, 0);
    wr1(8'h00, 8'h00);
    countTog(3, 5);
    check({6'h00, sdaOut, testPinOut}, 8'h00);
    wr1(8'h07, 8'h25);
    check({7'h0, testPinOe}, 8'h01);
    open(8'hD0, 1'b1);
    sendB(8'h07, 1'b1);
    open(8'hD1, 1'b1);
    rdB(8'h25, 1'b1);
    u_rtcs_bus_master.stop();
    onBackup <= 1'b1;
    u_rtcs_bus_master.waitc(8);
    check({7'h0, testPinOe}, 8'h00);
    onBackup <= 1'b0;
    u_rtcs_bus_master.waitc(8);
    $display("test pin_control done");
    powerFail <= 1'b1;
    u_rtcs_bus_master.waitc(10);
    open(8'hD0, 1'b0);
    u_rtcs_bus_master.stop();
    powerFail <= 1'b0;
    open(8'hD0, 1'b0);
    u_rtcs_bus_master.stop();
    u_rtcs_bus_master.waitc(LOCK);
    open(8'hD1, 1'b1);
    rdB(8'h00, 1'b1);
    u_rtcs_bus_master.stop();
    $display("test power_fail done");
    close_out();
  end
endmodule
`default_nettype wire
